// ===== design/rtu_defs.svh
// Constants of the serial slave framer: addresses, commands, answer codes, CRC and gap timing
`ifndef RTU_DEFS_SVH
`define RTU_DEFS_SVH

// ==========================================
// Addresses and commands
`define RTU_ADDR_BCAST 8'h00
`define RTU_ADDR_MAX 8'hF7
`define RTU_CMD_READ 8'h03
`define RTU_CMD_WRITE 8'h06
`define RTU_ERR_FLAG 8'h80
`define RTU_MAX_WORDS 16'h000C
`define RTU_REQ_LEN 4'h8

// ==========================================
// Error answer codes
`define RTU_EXC_NONE 8'h00
`define RTU_EXC_CMD 8'h01
`define RTU_EXC_ADDR 8'h02
`define RTU_EXC_VALUE 8'h03
`define RTU_EXC_FAIL 8'h04

// ==========================================
// Check value
`define RTU_CRC_PRESET 16'hFFFF
`define RTU_CRC_POLY 16'hA001

// ==========================================
// Timing
`define RTU_CLK_HZ 64'd100000000
`define RTU_BAUD 64'd9600
`define RTU_BITS_PER_CHAR 64'd11
`define RTU_GAP_HALF_CHARS 64'd7
`define RTU_GAP_CYCLES \
    32'((`RTU_CLK_HZ * `RTU_BITS_PER_CHAR * `RTU_GAP_HALF_CHARS + 64'd2 * `RTU_BAUD - 64'd1) / (64'd2 * `RTU_BAUD))

`endif

// ===== design/rtu_pkg.sv
// Types and the check value step of the serial slave framer
`include "rtu_defs.svh"

package rtu_pkg;

    // ==========================================
    // Framer states
    typedef enum logic [3:0] {
        S_IDLE, S_CHECK, S_ACC, S_HDR, S_RDW, S_RDB, S_CRC, S_DRAIN, S_GAP
    } rtu_state_t;

    // ==========================================
    // One byte through the check value register
    function automatic logic [15:0] rtu_crc_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `RTU_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : rtu_crc_step

endpackage : rtu_pkg

// ===== design/rtu_stream_if.sv
// Valid/ready byte stream between the framer and its transmit FIFO
interface rtu_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rtu_stream_if

// ===== design/rtu_crc.sv
// Running 16-bit check value register
`include "rtu_defs.svh"

module rtu_crc (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic init_in,
    input wire logic en_in,
    input wire logic [7:0] byte_in,
    output logic [15:0] crc_out
);

    // ==========================================
    // Register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            crc_out <= `RTU_CRC_PRESET;
        end else if (en_in) begin
            crc_out <= rtu_pkg::rtu_crc_step(init_in ? `RTU_CRC_PRESET : crc_out, byte_in);
        end else if (init_in) begin
            crc_out <= `RTU_CRC_PRESET;
        end
    end

    // ==========================================
    // Checks
    AST_CRC_PRESET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (init_in && !en_in) |=> (crc_out == `RTU_CRC_PRESET))
        else $error("check value not preset");
    AST_CRC_FIRST_BYTE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (init_in && en_in && byte_in == 8'h01) |=> (crc_out == 16'h807E))
        else $error("check value step wrong");

endmodule : rtu_crc

// ===== design/rtu_fifo.sv
// Transmit byte FIFO with registered output stage
module rtu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    rtu_stream_if.snk wr,
    rtu_stream_if.src rd,
    output logic empty_out
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign wr.ready = (count != FULL);
    assign empty_out = (count == '0);
    assign push = wr.valid && wr.ready;
    assign pop = (count != '0) && (!rd.valid || rd.ready);

    // ==========================================
    // Storage
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem[wptr] <= wr.data;
        end
    end

    // ==========================================
    // Pointers and fill
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end

    // ==========================================
    // Output stage
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rd.valid <= 1'b0;
            rd.data <= '0;
        end else if (pop) begin
            rd.valid <= 1'b1;
            rd.data <= mem[rptr];
        end else if (rd.ready) begin
            rd.valid <= 1'b0;
        end
    end

    AST_FIFO_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (rd.valid && !rd.ready) |=> (rd.valid && $stable(rd.data)))
        else $error("fifo output changed before taken");

endmodule : rtu_fifo

// ===== design/rtu_framer.sv
// Slave-side frame handler: gap delimiting, address filter, word read/write, check value, answers
`include "rtu_defs.svh"

module rtu_framer #(
    parameter int unsigned GAP_CYCLES = `RTU_GAP_CYCLES,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] slave_addr_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_err_in,
    output logic [7:0] tx_byte_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic tx_busy_in,
    output logic tx_en_out,
    output logic par_req_out,
    output logic par_we_out,
    output logic [15:0] par_addr_out,
    output logic [15:0] par_wdata_out,
    input wire logic par_ack_in,
    input wire logic par_err_in,
    input wire logic [15:0] par_rdata_in,
    output logic frame_drop_out
);

    rtu_pkg::rtu_state_t state;
    logic [7:0] rx_frame [8];
    logic [3:0] rx_cnt;
    logic rx_bad;
    logic [7:0] last_b;
    logic [7:0] prev_b;
    logic [15:0] crc_h1;
    logic [15:0] crc_h2;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic [31:0] gap_cnt;
    logic gap_done;
    logic [7:0] exc;
    logic [3:0] widx;
    logic [2:0] tx_idx;
    logic byte_sel;
    logic [15:0] rd_word;
    logic is_bcast;
    logic fifo_empty;
    logic wr_ready;
    logic push_valid;
    logic [7:0] push_byte;
    logic [7:0] hdr_byte;
    logic [2:0] hdr_len;
    logic own_ok;
    logic mine;
    logic bcast_hit;
    logic addr_hit;
    logic crc_ok;
    logic is_read;
    logic is_write;
    logic [15:0] par_addr;
    logic [15:0] par_val;
    logic [15:0] span_end;
    logic [3:0] last_w;
    logic [7:0] chk_exc;

    rtu_stream_if #(.WIDTH(8)) tx_wr ();
    rtu_stream_if #(.WIDTH(8)) tx_rd ();

    // ==========================================
    // Frame decode
    assign own_ok = (slave_addr_in != `RTU_ADDR_BCAST) && (slave_addr_in <= `RTU_ADDR_MAX);
    assign mine = own_ok && (rx_frame[0] == slave_addr_in);
    assign bcast_hit = (rx_frame[0] == `RTU_ADDR_BCAST);
    assign addr_hit = mine || bcast_hit;
    assign crc_ok = (rx_cnt >= 4'h4) && (crc_h2 == {last_b, prev_b});
    assign is_read = (rx_frame[1] == `RTU_CMD_READ);
    assign is_write = (rx_frame[1] == `RTU_CMD_WRITE);
    assign par_addr = {rx_frame[2], rx_frame[3]};
    assign par_val = {rx_frame[4], rx_frame[5]};
    assign span_end = 16'({8'h00, rx_frame[3]} + par_val - 16'h0001);
    assign last_w = is_read ? par_val[3:0] - 4'h1 : 4'h0;
    assign gap_done = (gap_cnt == GAP_CYCLES);

    always_comb begin
        chk_exc = `RTU_EXC_NONE;
        if (!is_read && !is_write) begin
            chk_exc = `RTU_EXC_CMD;
        end else if (rx_cnt != `RTU_REQ_LEN || rx_bad) begin
            chk_exc = `RTU_EXC_VALUE;
        end else if (is_read && (par_val == 16'h0000 || par_val > `RTU_MAX_WORDS)) begin
            chk_exc = `RTU_EXC_VALUE;
        end else if (is_read && span_end > 16'h00FF) begin
            chk_exc = `RTU_EXC_ADDR;
        end
    end

    // ==========================================
    // Receive capture
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                rx_frame[i] <= 8'h00;
            end
            rx_cnt <= 4'h0;
            rx_bad <= 1'b0;
            last_b <= 8'h00;
            prev_b <= 8'h00;
            crc_h1 <= `RTU_CRC_PRESET;
            crc_h2 <= `RTU_CRC_PRESET;
        end else if (state == rtu_pkg::S_CHECK) begin
            rx_cnt <= 4'h0;
            rx_bad <= 1'b0;
        end else if (state == rtu_pkg::S_IDLE && rx_valid_in) begin
            if (rx_cnt < `RTU_REQ_LEN) begin
                rx_frame[rx_cnt[2:0]] <= rx_byte_in;
            end
            if (rx_cnt != 4'hF) begin
                rx_cnt <= rx_cnt + 4'h1;
            end
            rx_bad <= rx_bad | rx_err_in;
            prev_b <= last_b;
            last_b <= rx_byte_in;
            crc_h1 <= (rx_cnt == 4'h0) ? `RTU_CRC_PRESET : rx_crc;
            crc_h2 <= crc_h1;
        end
    end

    rtu_crc u_rx_crc (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .init_in(state == rtu_pkg::S_IDLE && rx_valid_in && rx_cnt == 4'h0),
        .en_in(state == rtu_pkg::S_IDLE && rx_valid_in),
        .byte_in(rx_byte_in),
        .crc_out(rx_crc)
    );

    // ==========================================
    // Idle gap timer
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            gap_cnt <= 32'h0000_0000;
        end else if ((state == rtu_pkg::S_IDLE && rx_valid_in) ||
                     (state != rtu_pkg::S_IDLE && state != rtu_pkg::S_GAP)) begin
            gap_cnt <= 32'h0000_0000;
        end else if (!gap_done) begin
            gap_cnt <= gap_cnt + 32'h0000_0001;
        end
    end

    // ==========================================
    // Answer byte selection
    assign hdr_len = (exc == `RTU_EXC_NONE && is_write) ? 3'h6 : 3'h3;

    always_comb begin
        hdr_byte = rx_frame[tx_idx];
        if (tx_idx == 3'h1 && exc != `RTU_EXC_NONE) begin
            hdr_byte = rx_frame[1] | `RTU_ERR_FLAG;
        end else if (tx_idx == 3'h2 && exc != `RTU_EXC_NONE) begin
            hdr_byte = exc;
        end else if (tx_idx == 3'h2 && is_read) begin
            hdr_byte = {par_val[6:0], 1'b0};
        end
    end

    always_comb begin
        push_valid = 1'b0;
        push_byte = 8'h00;
        if (state == rtu_pkg::S_HDR) begin
            push_valid = 1'b1;
            push_byte = hdr_byte;
        end else if (state == rtu_pkg::S_RDB) begin
            push_valid = 1'b1;
            push_byte = byte_sel ? rd_word[7:0] : rd_word[15:8];
        end else if (state == rtu_pkg::S_CRC) begin
            push_valid = 1'b1;
            push_byte = byte_sel ? tx_crc[15:8] : tx_crc[7:0];
        end
    end

    assign tx_wr.valid = push_valid;
    assign tx_wr.data = push_byte;
    assign wr_ready = tx_wr.ready;
    assign tx_rd.ready = tx_ready_in;
    assign tx_valid_out = tx_rd.valid;
    assign tx_byte_out = tx_rd.data;

    rtu_crc u_tx_crc (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .init_in(state == rtu_pkg::S_CHECK),
        .en_in(push_valid && wr_ready && state != rtu_pkg::S_CRC),
        .byte_in(push_byte),
        .crc_out(tx_crc)
    );

    rtu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .wr(tx_wr.snk),
        .rd(tx_rd.src),
        .empty_out(fifo_empty)
    );

    // ==========================================
    // Line driver enable
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tx_en_out <= 1'b0;
        end else begin
            tx_en_out <= state inside {rtu_pkg::S_HDR, rtu_pkg::S_RDW, rtu_pkg::S_RDB,
                                       rtu_pkg::S_CRC, rtu_pkg::S_DRAIN};
        end
    end

    // ==========================================
    // Frame sequencer
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= rtu_pkg::S_IDLE;
            exc <= `RTU_EXC_NONE;
            widx <= 4'h0;
            tx_idx <= 3'h0;
            byte_sel <= 1'b0;
            rd_word <= 16'h0000;
            is_bcast <= 1'b0;
            par_req_out <= 1'b0;
            par_we_out <= 1'b0;
            par_addr_out <= 16'h0000;
            par_wdata_out <= 16'h0000;
            frame_drop_out <= 1'b0;
        end else begin
            frame_drop_out <= 1'b0;
            unique case (state)
                rtu_pkg::S_IDLE: begin
                    if (rx_cnt != 4'h0 && gap_done) begin
                        state <= rtu_pkg::S_CHECK;
                    end
                end
                rtu_pkg::S_CHECK: begin
                    is_bcast <= bcast_hit;
                    tx_idx <= 3'h0;
                    widx <= 4'h0;
                    byte_sel <= 1'b0;
                    exc <= chk_exc;
                    if (!addr_hit || !crc_ok) begin
                        frame_drop_out <= 1'b1;
                        state <= rtu_pkg::S_IDLE;
                    end else if (chk_exc != `RTU_EXC_NONE || (bcast_hit && is_read)) begin
                        state <= bcast_hit ? rtu_pkg::S_IDLE : rtu_pkg::S_HDR;
                    end else begin
                        state <= rtu_pkg::S_ACC;
                        par_req_out <= 1'b1;
                        par_we_out <= is_write;
                        par_addr_out <= par_addr;
                        par_wdata_out <= par_val;
                    end
                end
                rtu_pkg::S_ACC: begin
                    if (par_ack_in) begin
                        if (par_err_in || par_we_out || widx == last_w) begin
                            par_req_out <= 1'b0;
                            par_we_out <= 1'b0;
                            exc <= par_err_in ? `RTU_EXC_FAIL : `RTU_EXC_NONE;
                            state <= is_bcast ? rtu_pkg::S_IDLE : rtu_pkg::S_HDR;
                        end else begin
                            widx <= widx + 4'h1;
                            par_addr_out <= par_addr_out + 16'h0001;
                        end
                    end
                end
                rtu_pkg::S_HDR: begin
                    if (wr_ready) begin
                        if (tx_idx == hdr_len - 3'h1) begin
                            tx_idx <= 3'h0;
                            widx <= 4'h0;
                            if (exc == `RTU_EXC_NONE && is_read) begin
                                state <= rtu_pkg::S_RDW;
                                par_req_out <= 1'b1;
                                par_addr_out <= par_addr;
                            end else begin
                                state <= rtu_pkg::S_CRC;
                            end
                        end else begin
                            tx_idx <= tx_idx + 3'h1;
                        end
                    end
                end
                rtu_pkg::S_RDW: begin
                    if (par_ack_in) begin
                        par_req_out <= 1'b0;
                        rd_word <= par_rdata_in;
                        byte_sel <= 1'b0;
                        state <= rtu_pkg::S_RDB;
                    end
                end
                rtu_pkg::S_RDB: begin
                    if (wr_ready) begin
                        byte_sel <= !byte_sel;
                        if (byte_sel && widx == last_w) begin
                            state <= rtu_pkg::S_CRC;
                        end else if (byte_sel) begin
                            widx <= widx + 4'h1;
                            par_addr_out <= par_addr_out + 16'h0001;
                            par_req_out <= 1'b1;
                            state <= rtu_pkg::S_RDW;
                        end
                    end
                end
                rtu_pkg::S_CRC: begin
                    if (wr_ready) begin
                        byte_sel <= !byte_sel;
                        if (byte_sel) begin
                            state <= rtu_pkg::S_DRAIN;
                        end
                    end
                end
                rtu_pkg::S_DRAIN: begin
                    if (fifo_empty && !tx_valid_out && !tx_busy_in) begin
                        state <= rtu_pkg::S_GAP;
                    end
                end
                rtu_pkg::S_GAP: begin
                    if (gap_done) begin
                        state <= rtu_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    AST_HALF_DUPLEX: assert property (tx_valid_out |-> tx_en_out)
        else $error("transmit data without driver enable");
    AST_END_AFTER_GAP: assert property ((state == rtu_pkg::S_CHECK) |-> $past(gap_done))
        else $error("frame ended before idle gap");
    AST_REPLY_MINE: assert property (
        (state == rtu_pkg::S_CHECK && mine && crc_ok) |=> (state inside {rtu_pkg::S_ACC, rtu_pkg::S_HDR}))
        else $error("own frame not served");
    AST_NO_BCAST_REPLY: assert property ((state == rtu_pkg::S_HDR) |-> !is_bcast)
        else $error("answer to broadcast");
    AST_CMD_FILTER: assert property ((state == rtu_pkg::S_ACC) |-> (is_read || is_write))
        else $error("access for unknown command");
    AST_SPAN: assert property (
        (state == rtu_pkg::S_ACC && is_read) |-> (par_val >= 16'h0001 && par_val <= `RTU_MAX_WORDS &&
        span_end <= 16'h00FF))
        else $error("read span out of range");
    AST_ERR_FRAME: assert property (
        (state == rtu_pkg::S_HDR && exc != `RTU_EXC_NONE && tx_idx == 3'h1) |-> push_byte[7])
        else $error("error frame lacks error flag");
    AST_CRC_ORDER: assert property (
        (state == rtu_pkg::S_CRC && wr_ready && !byte_sel) |=> (push_byte == $past(tx_crc[15:8])))
        else $error("check value byte order wrong");
    AST_DROP_FOREIGN: assert property (
        (state == rtu_pkg::S_CHECK && (!addr_hit || !crc_ok)) |=> (state == rtu_pkg::S_IDLE && frame_drop_out))
        else $error("foreign or corrupt frame not dropped");

    COV_READ_REPLY: cover property (state == rtu_pkg::S_RDB ##1 state == rtu_pkg::S_CRC);
    COV_WRITE_REPLY: cover property (state == rtu_pkg::S_ACC && par_we_out && par_ack_in && !is_bcast);
    COV_ERROR_REPLY: cover property (state == rtu_pkg::S_HDR && exc != `RTU_EXC_NONE);
    COV_BCAST_WRITE: cover property (state == rtu_pkg::S_ACC && is_bcast && par_ack_in);
    COV_DROP: cover property (frame_drop_out);

endmodule : rtu_framer

// ===== dv/rtu_master_model.sv
// Bus master and transmit UART model facing the framer
module rtu_master_model #(
    parameter int BUSY = 3
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic tx_busy_out,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out,
    output logic rx_err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    int busy;
    initial begin
        rx_valid_out = 1'b0;
        rx_byte_out = 8'h00;
        rx_err_out = 1'b0;
    end
    // ====
    // Transmit side: take a byte, then shift it out
    assign tx_busy_out = busy != 0;
    assign tx_ready_out = busy == 0;
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            busy <= 0;
        end else if (tx_valid_in && tx_ready_out) begin
            got.push_back(tx_byte_in);
            busy <= BUSY;
        end else if (busy != 0) begin
            busy <= busy - 1;
        end
    end
    // ====
    // Master side: check value and frame sending
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction : crc16
    task automatic send(input logic [7:0] q[$], input logic bad, input logic err);
        logic [15:0] c;
        c = crc16(q);
        q.push_back(c[7:0] ^ {7'h00, bad});
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(posedge clk_sys_in);
            #1;
            rx_valid_out = 1'b1;
            rx_byte_out = q[i];
            rx_err_out = err;
            @(posedge clk_sys_in);
            #1;
            rx_valid_out = 1'b0;
            rx_byte_out = ~q[i];
            rx_err_out = 1'b0;
        end
    endtask : send
endmodule : rtu_master_model

// ===== dv/test_rtu_serial_slave_framer.sv
// Self-checking bench of the serial slave framer
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("BAD %s exp %h got %h", nm, e, a); end end
module test_rtu_serial_slave_framer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] tx_byte, rx_byte;
    logic tx_valid, tx_ready, tx_busy, tx_en, rx_valid, rx_err, par_req, par_we, par_err, drop;
    logic par_ack = 1'b0;
    logic [7:0] own = 8'h11;
    logic [15:0] par_addr, par_wdata, par_rdata;
    logic [31:0] wr_log[$];
    logic [7:0] none[$];
    int failures = 0;
    int cmp_count = 0;
    int drops = 0;
    int en_bad = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    rtu_framer #(.GAP_CYCLES(40)) DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .slave_addr_in(own),
        .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_err_in(rx_err), .tx_byte_out(tx_byte),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_busy_in(tx_busy), .tx_en_out(tx_en),
        .par_req_out(par_req), .par_we_out(par_we), .par_addr_out(par_addr), .par_wdata_out(par_wdata),
        .par_ack_in(par_ack), .par_err_in(par_err), .par_rdata_in(par_rdata), .frame_drop_out(drop));
    rtu_master_model m (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .tx_busy_out(tx_busy), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte),
        .rx_err_out(rx_err));
    // ====
    // Parameter store stand-in and line watchers
    assign par_rdata = par_addr ^ 16'hA5A5;
    assign par_err = par_addr == 16'h00EE;
    always @(posedge clk_sys_in) begin
        par_ack <= #1 par_req && !par_ack;
        if (par_req === 1'b1 && !par_ack && par_we === 1'b1) wr_log.push_back({par_addr, par_wdata});
        if (drop === 1'b1) drops++;
        if (tx_valid === 1'b1 && tx_en !== 1'b1) en_bad++;
    end
    // ====
    // Scenarios
    task automatic run(input logic [7:0] q[$], input logic bad, input logic err, input logic [7:0] e[$]);
        logic [15:0] c;
        c = m.crc16(e);
        if (e.size() != 0) e = {e, c[7:0], c[15:8]};
        m.got.delete();
        m.send(q, bad, err);
        repeat (300) @(posedge clk_sys_in);
        #1;
        `CHK("len", e.size(), m.got.size())
        foreach (e[i]) `CHK("byte", e[i], m.got[i])
    endtask : run
    task automatic t_write();
        logic [7:0] w[$];
        w = '{8'h11, 8'h06, 8'h00, 8'h10, 8'h12, 8'h34};
        run(w, 1'b0, 1'b0, w);
        `CHK("wr", 32'h00101234, wr_log[$])
    endtask : t_write
    task automatic t_read();
        run('{8'h11, 8'h03, 8'h00, 8'hFD, 8'h00, 8'h03}, 1'b0, 1'b0,
            '{8'h11, 8'h03, 8'h06, 8'hA5, 8'h58, 8'hA5, 8'h5B, 8'hA5, 8'h5A});
    endtask : t_read
    task automatic t_errs();
        run('{8'h11, 8'h03, 8'h00, 8'hFE, 8'h00, 8'h03}, 1'b0, 1'b0, '{8'h11, 8'h83, 8'h02});
        run('{8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h0D}, 1'b0, 1'b0, '{8'h11, 8'h83, 8'h03});
        run('{8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00}, 1'b0, 1'b0, '{8'h11, 8'h83, 8'h03});
        run('{8'h11, 8'h04, 8'h00, 8'h10, 8'h00, 8'h01}, 1'b0, 1'b0, '{8'h11, 8'h84, 8'h01});
        run('{8'h11, 8'h06, 8'h00, 8'hEE, 8'h00, 8'h01}, 1'b0, 1'b0, '{8'h11, 8'h86, 8'h04});
        run('{8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01}, 1'b0, 1'b1, '{8'h11, 8'h83, 8'h03});
        run('{8'h11, 8'h06, 8'h00, 8'h10, 8'h12}, 1'b0, 1'b0, '{8'h11, 8'h86, 8'h03});
    endtask : t_errs
    task automatic t_bcast();
        run('{8'h00, 8'h06, 8'h00, 8'h20, 8'hBE, 8'hEF}, 1'b0, 1'b0, none);
        `CHK("bc", 32'h0020BEEF, wr_log[$])
        run('{8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01}, 1'b0, 1'b0, none);
    endtask : t_bcast
    task automatic t_drop();
        int d;
        int n;
        d = drops;
        n = wr_log.size();
        run('{8'h01, 8'h06, 8'h00, 8'h30, 8'h00, 8'h01}, 1'b0, 1'b0, none);
        run('{8'h11, 8'h06, 8'h00, 8'h30, 8'h00, 8'h01}, 1'b1, 1'b0, none);
        own = 8'hF8;
        run('{8'hF8, 8'h06, 8'h00, 8'h30, 8'h00, 8'h01}, 1'b0, 1'b0, none);
        own = 8'h11;
        `CHK("drop", d + 3, drops)
        `CHK("wrn", n, wr_log.size())
    endtask : t_drop
    task automatic summarize();
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        t_write();
        t_read();
        t_errs();
        t_bcast();
        t_drop();
        `CHK("en", 0, en_bad)
        summarize();
    end
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule : test_rtu_serial_slave_framer
